// *** logic/diag_pkg.sv ***
package diag_pkg;

	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] CTRL_ADDR = 8'h00;
	localparam logic [7:0] STATUS_ADDR = 8'h04;
	localparam logic [7:0] CH0_ADDR = 8'h10;
	localparam logic [7:0] CH1_ADDR = 8'h14;
	localparam logic [7:0] CH2_ADDR = 8'h18;
	localparam logic [7:0] CH3_ADDR = 8'h1C;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int AMP_START_POS = 0;
	localparam int DIAG_ENABLE_POS = 1;
	localparam int READBACK_SEL_POS = 4;
	localparam int AMP_RUNNING_POS = 0;
	localparam int DIAG_BUSY_POS = 5;
	localparam int LOW_GAIN_POS = 1;
	localparam int SHORT_GND_POS = 0;
	localparam int SHORT_SUP_POS = 1;
	localparam int OFFSET_POS = 2;
	localparam int SHORTED_POS = 3;
	localparam int CODE_LO_POS = 4;

	// ----------------------------------------
	// Load codes and reset values
	// ----------------------------------------
	localparam logic [1:0] CODE_NORMAL = 2'h0;
	localparam logic [1:0] CODE_LINE = 2'h1;
	localparam logic [1:0] CODE_OPEN = 2'h2;
	localparam logic [1:0] CODE_INVALID = 2'h3;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_HZ = 20000000;
	localparam int RAMP_MS = 15;
	localparam int RAMP_CYC = RAMP_MS * (CLK_HZ / 1000);
	localparam int MEAS_CYC = 1000;
	localparam int STARTUP_CYC = 1000;
	localparam int FILT_CYC = 4;

	typedef enum {
		ST_IDLE, ST_RAMP_UP, ST_OFFSET_HI, ST_MEASURE, ST_RAMP_DOWN, ST_STARTUP, ST_RUN,
		ST_SHUTDOWN
	} diag_state_t;

	// Analogue comparator results for one channel
	typedef struct packed {
		logic out_over;
		logic short_sup;
		logic short_gnd;
		logic shorted;
		logic open_load;
		logic booster;
		logic in_window;
	} chan_sense_t;

	// Per-channel readable result
	typedef struct packed {
		logic [1:0] code;
		logic shorted;
		logic offset;
		logic short_sup;
		logic short_gnd;
	} chan_result_t;

endpackage : diag_pkg

// *** logic/startup_load_diagnostics.sv ***
// Notes on behaviour
// RQ1 - With diagnostics on, classify four channels; detect booster and supply/ground shorts.
// RQ2 - First stage applies offset, raises it only after 15 ms.
// RQ3 - After measurement, lower offset after a further 15 ms, not abruptly.
// RQ4 - Output above 3.5 V during first stage aborts the sequence.
// RQ5 - Channel shorted to supply reports invalid after first stage.
// RQ6 - Spikes and door-slam are filtered so one cycle gives a reliable result.
// RQ7 - Cycle start sets all codes invalid and asserts busy.
// RQ8 - Busy clears on completion or on power-on reset.
// RQ9 - Diag only: clear busy, post results; toggling enable restarts the cycle.
// RQ10 - Diag plus start: amp starts after cycle, busy clears before mute release. Code clears busy once mute release is seen, or after STARTUP_CYCLES.
// RQ11 - Host waits busy low, reads, clears start, waits running status low.
// RQ12 - Code: 00 normal, 01 line driver, 10 open, 11 invalid.
// RQ13 - Engine start during diagnostics sets affected code invalid.
// RQ14 - Results readable only while readback select is 0; values kept.
// RQ15 - Shorted, supply and ground short flags clear after each read.
// RQ16 - Load code updated only by a new cycle, never by reads.
// RQ17 - Reading a channel's status sets its offset latch.
// RQ18 - Output inside offset window clears the latch and blocks setting until read.
// RQ19 - Flags on bits 3, 1, 0; when set, load code is meaningless.
// RQ20 - Shorted load reported for impedance up to 1.5 ohm.
// RQ21 - Booster found: may start in line-driver mode with low gain.
// RQ22 - Host treats one or two invalid as supply short, four as supply fault.
//
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
module startup_load_diagnostics #(
	parameter int RAMP_CYCLES = diag_pkg::RAMP_CYC,
	parameter int MEAS_CYCLES = diag_pkg::MEAS_CYC,
	parameter int STARTUP_CYCLES = diag_pkg::STARTUP_CYC,
	parameter int FILT_CYCLES = diag_pkg::FILT_CYC
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire diag_pkg::chan_sense_t [3:0] sense_i,
	input wire logic engine_start_i,
	input wire logic supply_bad_i,
	input wire logic mute_release_i,
	output logic offset_apply_o,
	output logic offset_high_o,
	output logic amp_enable_o,
	output logic low_gain_o
);
	import diag_pkg::*;

	// ----------------------------------------
	// Input synchronisers (three stages)
	// ----------------------------------------
	localparam int SW = 4 * 7 + 3;
	logic [SW-1:0] s1_r, s2_r, s3_r, in_r, in_nxt;
	logic [SW-1:0] raw;
	assign raw = {sense_i, engine_start_i, supply_bad_i, mute_release_i};

	always_comb begin
		in_nxt = in_r;
		for (int i = 0; i < SW; i++) begin
			if (s2_r[i] == s3_r[i]) begin
				in_nxt[i] = s3_r[i];
			end
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			in_r <= '0;
		end else begin
			s1_r <= raw;
			s2_r <= s1_r;
			s3_r <= s2_r;
			in_r <= in_nxt;
		end
	end

	chan_sense_t [3:0] sn;
	logic eng_start, sup_bad, mute_rel;
	assign {sn, eng_start, sup_bad, mute_rel} = in_r;

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	function automatic logic [1:0] chan_index(input logic [7:0] a);
		chan_index = a[3:2];
	endfunction : chan_index

	function automatic logic is_chan(input logic [7:0] a);
		is_chan = (a == CH0_ADDR) || (a == CH1_ADDR) || (a == CH2_ADDR) || (a == CH3_ADDR);
	endfunction : is_chan

	logic acc, wr, rd;
	assign acc = psel_i & penable_i;
	assign wr = acc & pwrite_i;
	assign rd = acc & ~pwrite_i;
	assign pready_o = 1'b1;
	assign pslverr_o = acc & ~((paddr_i == CTRL_ADDR) || (paddr_i == STATUS_ADDR)
		|| is_chan(paddr_i));

	logic [7:0] ctrl_r, ctrl_nxt;
	logic diag_en, amp_start, rb_sel;
	assign diag_en = ctrl_r[DIAG_ENABLE_POS];
	assign amp_start = ctrl_r[AMP_START_POS];
	assign rb_sel = ctrl_r[READBACK_SEL_POS];

	always_comb begin
		ctrl_nxt = ctrl_r;
		if (wr && paddr_i == CTRL_ADDR) begin
			ctrl_nxt = pwdata_i[7:0];
		end
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	diag_state_t st_r, st_nxt;
	logic [31:0] cnt_r, cnt_nxt;
	logic busy_r, busy_nxt;
	logic diag_en_d_r, diag_en_d_nxt;
	// Engine start seen during the ramp-up, offset-high or measure stages (not during ramp-down)
	logic eng_seen_r, eng_seen_nxt;
	logic [3:0] over_r, over_nxt;
	logic [3:0][FILT_CYCLES-1:0] flt_r, flt_nxt;
	logic [3:0][1:0] code_r, code_nxt;
	logic [3:0] shorted_r, shorted_nxt, ssup_r, ssup_nxt, sgnd_r, sgnd_nxt;
	logic [3:0] ofs_r, ofs_nxt, ofs_blk_r, ofs_blk_nxt;
	logic low_gain_r, low_gain_nxt;
	logic restart, abort;

	assign restart = diag_en && !diag_en_d_r; // [RQ9]
	assign abort = |over_r; // [RQ4]

	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r + 32'h1;
		busy_nxt = busy_r;
		code_nxt = code_r;
		over_nxt = over_r;
		flt_nxt = flt_r;
		low_gain_nxt = low_gain_r;
		// Enable edge tracked only while idle, so a toggle mid-cycle cannot restart
		diag_en_d_nxt = (st_r == ST_IDLE) ? diag_en : diag_en_d_r;
		eng_seen_nxt = eng_seen_r;
		for (int c = 0; c < 4; c++) begin
			// Spike filter: open load counts only if high for FILT_CYCLES samples
			flt_nxt[c] = {flt_r[c][FILT_CYCLES-2:0], sn[c].open_load}; // [RQ6]
		end
		case (st_r)
			ST_IDLE: begin
				cnt_nxt = '0;
				if (restart) begin
					st_nxt = ST_RAMP_UP;
					busy_nxt = 1'b1; // [RQ7]
					code_nxt = {4{CODE_INVALID}}; // [RQ7]
					over_nxt = '0;
					eng_seen_nxt = 1'b0;
				end else if (diag_en && amp_start && !busy_r) begin
					st_nxt = ST_STARTUP;
				end
			end
			ST_RAMP_UP: begin
				for (int c = 0; c < 4; c++) begin
					over_nxt[c] = over_r[c] | sn[c].out_over; // [RQ4]
				end
				if (abort) begin
					st_nxt = ST_RAMP_DOWN;
					cnt_nxt = '0;
				end else if (cnt_r >= 32'(RAMP_CYCLES - 1)) begin
					st_nxt = ST_OFFSET_HI; // [RQ2]
					cnt_nxt = '0;
				end
			end
			ST_OFFSET_HI, ST_MEASURE: begin
				for (int c = 0; c < 4; c++) begin
					over_nxt[c] = over_r[c] | sn[c].out_over; // [RQ4]
				end
				if (abort) begin
					st_nxt = ST_RAMP_DOWN;
					cnt_nxt = '0;
				end else if (cnt_r >= 32'(MEAS_CYCLES - 1)) begin
					st_nxt = ST_RAMP_DOWN;
					cnt_nxt = '0;
					low_gain_nxt = 1'b0;
					for (int c = 0; c < 4; c++) begin // [RQ1] [RQ12]
						if (sn[c].short_sup || sup_bad || eng_start || eng_seen_r) begin
							code_nxt[c] = CODE_INVALID; // [RQ5] [RQ13]
						end else if (sn[c].booster) begin
							code_nxt[c] = CODE_LINE;
							low_gain_nxt = 1'b1; // [RQ21]
						end else if (&flt_r[c]) begin
							code_nxt[c] = CODE_OPEN; // [RQ6]
						end else begin
							code_nxt[c] = CODE_NORMAL;
						end
					end
				end
			end
			ST_RAMP_DOWN: begin
				if (cnt_r >= 32'(RAMP_CYCLES - 1)) begin // [RQ3]
					cnt_nxt = '0;
					if (diag_en && amp_start && !abort) begin
						st_nxt = ST_STARTUP; // [RQ10]
					end else begin
						st_nxt = ST_IDLE;
						busy_nxt = 1'b0; // [RQ8] [RQ9]
					end
				end
			end
			ST_STARTUP: begin
				if (!amp_start) begin
					st_nxt = ST_SHUTDOWN;
				end else if (mute_rel || cnt_r >= 32'(STARTUP_CYCLES - 1)) begin
					st_nxt = ST_RUN;
					busy_nxt = 1'b0; // [RQ10]
				end
			end
			ST_RUN: begin
				if (!amp_start) begin
					st_nxt = ST_SHUTDOWN;
					cnt_nxt = '0;
				end
			end
			ST_SHUTDOWN: begin
				busy_nxt = 1'b0;
				st_nxt = ST_IDLE;
			end
			default: begin
				st_nxt = ST_IDLE;
			end
		endcase
		// Engine start while measuring spoils every code
		if ((st_r == ST_OFFSET_HI || st_r == ST_MEASURE || st_r == ST_RAMP_UP)
			&& eng_start) begin
			code_nxt = {4{CODE_INVALID}}; // [RQ13]
			// Remembered so an earlier start still spoils the codes at evaluation
			eng_seen_nxt = 1'b1; // [RQ13]
		end
	end

	// ----------------------------------------
	// Fault flags and offset latches
	// ----------------------------------------
	logic rd_chan, rd_setup;
	logic [1:0] rd_idx;
	// Read word is captured in the setup cycle and shown during the access cycle
	logic [31:0] rdata_r, rdata_nxt;
	assign rd_setup = psel_i & ~penable_i & ~pwrite_i;
	assign rd_chan = rd && is_chan(paddr_i) && !rb_sel;
	assign rd_idx = chan_index(paddr_i);

	always_comb begin
		shorted_nxt = shorted_r;
		ssup_nxt = ssup_r;
		sgnd_nxt = sgnd_r;
		ofs_nxt = ofs_r;
		ofs_blk_nxt = ofs_blk_r;
		for (int c = 0; c < 4; c++) begin
			if (rd_chan && rd_idx == 2'(c)) begin
				// Only bits returned by this read clear, so a set landing mid-read survives
				shorted_nxt[c] = shorted_r[c] & ~rdata_r[SHORTED_POS]; // [RQ15]
				ssup_nxt[c] = ssup_r[c] & ~rdata_r[SHORT_SUP_POS];
				sgnd_nxt[c] = sgnd_r[c] & ~rdata_r[SHORT_GND_POS];
				ofs_nxt[c] = 1'b1; // [RQ17]
				ofs_blk_nxt[c] = 1'b0;
			end
			// Set wins over read clear
			if (sn[c].shorted) begin
				shorted_nxt[c] = 1'b1; // [RQ20]
			end
			if (sn[c].short_sup) begin
				ssup_nxt[c] = 1'b1;
			end
			if (sn[c].short_gnd) begin
				sgnd_nxt[c] = 1'b1;
			end
			if (sn[c].in_window) begin
				ofs_nxt[c] = 1'b0; // [RQ18]
				ofs_blk_nxt[c] = 1'b1;
			end else if (ofs_blk_r[c] && !(rd_chan && rd_idx == 2'(c))) begin
				ofs_nxt[c] = 1'b0; // [RQ18]
			end
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ctrl_r <= CTRL_RESET;
			st_r <= ST_IDLE;
			cnt_r <= '0;
			busy_r <= 1'b0; // [RQ8]
			diag_en_d_r <= 1'b0;
			eng_seen_r <= 1'b0;
			over_r <= '0;
			flt_r <= '0;
			code_r <= {4{CODE_INVALID}};
			low_gain_r <= 1'b0;
			shorted_r <= '0;
			ssup_r <= '0;
			sgnd_r <= '0;
			ofs_r <= '0;
			ofs_blk_r <= '0;
		end else begin
			ctrl_r <= ctrl_nxt;
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			busy_r <= busy_nxt;
			diag_en_d_r <= diag_en_d_nxt;
			eng_seen_r <= eng_seen_nxt;
			over_r <= over_nxt;
			flt_r <= flt_nxt;
			code_r <= code_nxt; // [RQ16]
			low_gain_r <= low_gain_nxt;
			shorted_r <= shorted_nxt;
			ssup_r <= ssup_nxt;
			sgnd_r <= sgnd_nxt;
			ofs_r <= ofs_nxt;
			ofs_blk_r <= ofs_blk_nxt;
		end
	end

	// ----------------------------------------
	// Read data and outputs
	// ----------------------------------------
	chan_result_t res;

	always_comb begin
		rdata_nxt = '0;
		res = '0;
		if (rd_setup) begin
			if (paddr_i == CTRL_ADDR) begin
				rdata_nxt[7:0] = ctrl_r;
			end else if (paddr_i == STATUS_ADDR) begin
				rdata_nxt[DIAG_BUSY_POS] = busy_r;
				rdata_nxt[AMP_RUNNING_POS] = (st_r == ST_STARTUP) || (st_r == ST_RUN);
				rdata_nxt[LOW_GAIN_POS] = low_gain_r;
			end else if (is_chan(paddr_i) && !rb_sel) begin // [RQ14]
				res.code = code_r[rd_idx];
				res.shorted = shorted_r[rd_idx]; // [RQ19]
				res.offset = ofs_r[rd_idx];
				res.short_sup = ssup_r[rd_idx];
				res.short_gnd = sgnd_r[rd_idx];
				rdata_nxt[5:0] = res;
			end
		end
	end

	// Cleared in the access cycle, so the bus reads zero outside transfers
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_r <= '0;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	assign prdata_o = rdata_r;

	// ----------------------------------------
	// Stage outputs
	// ----------------------------------------
	assign offset_apply_o = (st_r == ST_RAMP_UP) || (st_r == ST_OFFSET_HI)
		|| (st_r == ST_MEASURE) || (st_r == ST_RAMP_DOWN);
	assign offset_high_o = (st_r == ST_OFFSET_HI) || (st_r == ST_MEASURE); // [RQ2] [RQ3]
	assign amp_enable_o = (st_r == ST_STARTUP) || (st_r == ST_RUN);
	assign low_gain_o = low_gain_r; // [RQ21]

endmodule : startup_load_diagnostics

// *** tb/host_model.sv ***
`timescale 1ns/1ps
module host_model (
	input wire logic clk_i,
	input wire logic [31:0] prdata_i,
	input wire logic pready_i,
	input wire logic pslverr_i,
	output logic psel_o,
	output logic penable_o,
	output logic pwrite_o,
	output logic [7:0] paddr_o,
	output logic [31:0] pwdata_o
);
	int timeouts = 0;
	initial begin
		psel_o = 1'b0;
		penable_o = 1'b0;
		pwrite_o = 1'b0;
		paddr_o = 8'h00;
		pwdata_o = 32'h0;
	end
	// Request held until pready seen at a rising edge or 20 edges pass; answer taken in that cycle
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		logic r;
		int n;
		@(posedge clk_i);
		psel_o <= 1'b1;
		pwrite_o <= w;
		paddr_o <= a;
		pwdata_o <= d;
		@(posedge clk_i);
		penable_o <= 1'b1;
		n = 0;
		r = 1'b0;
		while (!r && n < 20) begin
			@(posedge clk_i);
			q = prdata_i;
			e = pslverr_i;
			r = (pready_i === 1'b1);
			n++;
		end
		if (!r) begin
			timeouts++;
		end
		psel_o <= 1'b0;
		penable_o <= 1'b0;
		paddr_o <= ~a;
		pwdata_o <= ~d;
	endtask : xfer
endmodule : host_model

// *** tb/diag_props.sv ***
`timescale 1ns/1ps
module diag_props
	import diag_pkg::*;
	#(parameter int RAMP_CYCLES = 20) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic offset_apply_o,
	input wire logic offset_high_o,
	input wire logic amp_enable_o
);
	logic acc;
	logic chn;
	logic [7:0] ctl_r;
	int cnt_r;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	assign acc = psel_i && penable_i;
	assign chn = paddr_i inside {CH0_ADDR, CH1_ADDR, CH2_ADDR, CH3_ADDR};
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ctl_r <= 8'h00;
			cnt_r <= 0;
		end else begin
			if (acc && pwrite_i && paddr_i == CTRL_ADDR) begin
				ctl_r <= pwdata_i[7:0];
			end
			cnt_r <= (offset_apply_o && !offset_high_o) ? cnt_r + 1 : 0;
		end
	end
	a_ready_high: assert property (acc |-> pready_o)
		else $error("pready low");
	a_rdata_idle: assert property (!acc |-> prdata_o == 32'h0)
		else $error("read data outside access");
	a_slverr_map: assert property (acc |->
		pslverr_o == !(chn || paddr_i == CTRL_ADDR || paddr_i == STATUS_ADDR))
		else $error("error response wrong");
	a_ctrl_read: assert property (acc && !pwrite_i && paddr_i == CTRL_ADDR |->
		prdata_o[4] == ctl_r[4] && prdata_o[1:0] == ctl_r[1:0])
		else $error("control readback wrong");
	a_hidden_results: assert property (
		acc && !pwrite_i && ctl_r[4] && chn |-> prdata_o == 32'h0)
		else $error("results not hidden");
	a_ramp_up: assert property ($rose(offset_high_o) |-> cnt_r >= RAMP_CYCLES - 1)
		else $error("offset raised early");
	a_high_applied: assert property (offset_high_o |-> offset_apply_o)
		else $error("raised offset without offset");
	a_ramp_down: assert property (
		$fell(offset_high_o) && offset_apply_o |-> offset_apply_o [*8])
		else $error("offset removed abruptly");
	a_amp_after_diag: assert property (offset_apply_o |-> !amp_enable_o)
		else $error("amplifier on during measurement");
	a_reset_quiet: assert property ($rose(rstn_i) |-> !amp_enable_o && !offset_apply_o)
		else $error("outputs active after reset");
endmodule : diag_props
bind startup_load_diagnostics diag_props #(.RAMP_CYCLES(RAMP_CYCLES)) diag_props_inst (
	.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
	.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
	.pready_o(pready_o), .pslverr_o(pslverr_o), .offset_apply_o(offset_apply_o),
	.offset_high_o(offset_high_o), .amp_enable_o(amp_enable_o));

// *** tb/startup_load_diagnostics_tb.sv ***
`timescale 1ns/1ps
module startup_load_diagnostics_tb;
	import diag_pkg::*;
	logic clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, e, apply, high, amp, gain;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	chan_sense_t [3:0] sense = '0;
	logic eng = 1'b0;
	logic mute = 1'b0;
	logic [31:0] exp4 [4] = '{32'h00, 32'h20, 32'h10, 32'h32};
	int n_errors = 0;
	int total_checks = 0;
	int k;
	always #25 clk_i = ~clk_i;
	startup_load_diagnostics #(.RAMP_CYCLES(20), .MEAS_CYCLES(30), .STARTUP_CYCLES(40))
		startup_load_diagnostics_inst (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .sense_i(sense),
		.engine_start_i(eng), .supply_bad_i(1'b0), .mute_release_i(mute),
		.offset_apply_o(apply), .offset_high_o(high), .amp_enable_o(amp), .low_gain_o(gain));
	host_model host_model_inst (.clk_i(clk_i), .prdata_i(prdata), .pready_i(pready),
		.pslverr_i(pslverr), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
		.paddr_o(paddr), .pwdata_o(pwdata));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic stop_test();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : stop_test
	// A bus timeout ends the run at once
	task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
		host_model_inst.xfer(w, a, d, q, e);
		if (host_model_inst.timeouts != 0) begin
			n_errors++;
			stop_test();
		end
	endtask : xf
	task automatic rd(input logic [7:0] a);
		xf(1'b0, a, 32'h0);
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xf(1'b1, a, d);
	endtask : wr
	// Polls a status bit, reading it at least once; a bound that runs out ends the run
	task automatic wait_bit(input int pos, input logic v);
		int i;
		rd(STATUS_ADDR);
		for (i = 0; i < 100 && q[pos] !== v; i++) begin
			rd(STATUS_ADDR);
		end
		if (q[pos] !== v) begin
			n_errors++;
			stop_test();
		end
	endtask : wait_bit
	initial begin
		repeat (3) @(posedge clk_i);
		rstn_i <= 1'b1;
		rd(CTRL_ADDR);
		chk(q, 32'h0);
		rd(STATUS_ADDR);
		chk(q & 32'h21, 32'h0);
		rd(CH0_ADDR);
		chk(q & 32'h30, 32'h30);
		rd(8'h08);
		chk({31'h0, e}, 32'h1);
		$display("test 1 done");
		sense[1].open_load <= 1'b1;
		sense[2].booster <= 1'b1;
		sense[3].short_sup <= 1'b1;
		wr(CTRL_ADDR, 32'h2);
		rd(STATUS_ADDR);
		chk(q & 32'h20, 32'h20);
		rd(CH1_ADDR);
		chk(q & 32'h30, 32'h30);
		wait_bit(DIAG_BUSY_POS, 1'b0);
		for (k = 0; k < 4; k++) begin
			rd(CH0_ADDR + 8'(4 * k));
			chk(q & 32'h3B, exp4[k]);
		end
		rd(STATUS_ADDR);
		chk(q & 32'h21, 32'h0);
		chk(q & 32'h2, 32'h2);
		chk({31'h0, gain}, 32'h1);
		$display("test 2 done");
		sense[3].short_sup <= 1'b0;
		repeat (6) @(posedge clk_i);
		rd(CH3_ADDR);
		rd(CH3_ADDR);
		chk(q & 32'h3B, 32'h30);
		rd(CH0_ADDR);
		chk(q & 32'h4, 32'h4);
		sense[0].in_window <= 1'b1;
		repeat (6) @(posedge clk_i);
		rd(CH0_ADDR);
		chk(q & 32'h4, 32'h0);
		sense[0].in_window <= 1'b0;
		wr(CTRL_ADDR, 32'h12);
		rd(CH1_ADDR);
		chk(q, 32'h0);
		wr(CTRL_ADDR, 32'h2);
		rd(CH1_ADDR);
		chk(q & 32'h30, 32'h20);
		$display("test 3 done");
		wr(CTRL_ADDR, 32'h0);
		wr(CTRL_ADDR, 32'h2);
		rd(STATUS_ADDR);
		chk(q & 32'h20, 32'h20);
		eng <= 1'b1;
		repeat (8) @(posedge clk_i);
		eng <= 1'b0;
		wait_bit(DIAG_BUSY_POS, 1'b0);
		rd(CH0_ADDR);
		chk(q & 32'h30, 32'h30);
		$display("test 4 done");
		wr(CTRL_ADDR, 32'h0);
		wr(CTRL_ADDR, 32'h3);
		for (k = 0; k < 300 && amp !== 1'b1; k++) begin
			@(posedge clk_i);
		end
		chk({31'h0, amp}, 32'h1);
		rd(STATUS_ADDR);
		chk(q & 32'h20, 32'h20);
		mute <= 1'b1;
		wait_bit(DIAG_BUSY_POS, 1'b0);
		chk(q & 32'h1, 32'h1);
		mute <= 1'b0;
		wr(CTRL_ADDR, 32'h2);
		wait_bit(AMP_RUNNING_POS, 1'b0);
		$display("test 5 done");
		wr(CTRL_ADDR, 32'h0);
		wr(CTRL_ADDR, 32'h2);
		rd(STATUS_ADDR);
		chk(q & 32'h20, 32'h20);
		rstn_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rstn_i <= 1'b1;
		rd(STATUS_ADDR);
		chk(q & 32'h21, 32'h0);
		rd(CH0_ADDR);
		chk(q & 32'h30, 32'h30);
		$display("test 6 done");
		sense[0].out_over <= 1'b1;
		wr(CTRL_ADDR, 32'h0);
		wr(CTRL_ADDR, 32'h2);
		wait_bit(DIAG_BUSY_POS, 1'b0);
		rd(CH0_ADDR);
		chk(q & 32'h30, 32'h30);
		chk(32'(host_model_inst.timeouts), 32'h0);
		$display("test 7 done");
		stop_test();
	end
endmodule : startup_load_diagnostics_tb
